// ---- core/nvac_ctrl.sv ----
// Byte access controller for a 512-byte nonvolatile data store.
// Assumes the CPU port is synchronous to i_sys_clk and i_tick_1mhz
// is a one-cycle pulse at 1 MHz from the calibrated oscillator.
// Operation
// R01 - Nine-bit address selects one of 512 bytes, linear from 0 to 511.
// R02 - Unused upper address-high bits and control bits 7:4 read zero.
// R03 - Address is undefined at power-up; software loads it before access.
// R04 - Data register supplies write byte and receives read byte.
// R05 - Ready interrupt asserted while enabled, global flag set, write strobe clear.
// R06 - Master write arm clears itself four cycles after software sets it.
// R07 - Write strobe starts a write only while the arm bit is set.
// R08 - Write strobe stays set during write; hardware clears it when done.
// R09 - Starting a write stalls the CPU two cycles.
// R10 - Read strobe fetches addressed byte into data register, then stalls four.
// R11 - During a write, reads are ignored and address cannot change.
// R12 - Write lasts 8448 ticks of the 1 MHz oscillator, about 8.5 ms.
// R13 - No programming while the CPU is writing Flash.
// R14 - Software waits idle, loads address and data, arms, strobes within four.
// R15 - Software should keep interrupts off during the write sequence.
// R16 - Write finishes in power-down; oscillator keeps running.
// R17 - Reset during a write does not abort it.
// R18 - Reset clears control bits once any write has completed.
module nvac_ctrl (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // CPU register port
   input wire logic [1:0] i_reg_sel,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // System status
   input wire logic i_global_irq_en,
   input wire logic i_flash_selfprog_busy,
   input wire logic i_power_down,
   input wire logic i_tick_1mhz,
   // Outputs to the core
   output logic o_cpu_stall,
   output logic o_ready_irq,
   output logic o_osc_request
);
   import nvac_pkg::*;

   nvac_mem_if mif ();
   nvac_state_t state_reg;
   logic [8:0] nv_byte_address_reg;
   logic [7:0] nv_data_byte_reg;
   logic ready_irq_enable_reg;
   logic master_write_arm_reg;
   logic write_strobe_reg;
   logic [2:0] arm_count_reg;
   logic [2:0] stall_count_reg;
   logic [13:0] tick_count_reg;
   logic read_pending_reg;
   logic [7:0] rdata_reg;
   logic ctl_wr;
   logic busy;
   logic write_start;
   logic read_start;
   logic write_done;

   // Helper: is this a write to the given register
   function automatic logic sel_hit(input logic [1:0] sel, input logic [1:0] code, input logic wr);
      sel_hit = wr && (sel == code);
   endfunction : sel_hit

   nvac_byte_array u_array (
      .i_sys_clk(i_sys_clk),
      .m(mif.mem)
   );

   // Decode of control writes and write/read launch conditions
   assign ctl_wr = sel_hit(i_reg_sel, NVAC_SEL_CONTROL, i_reg_wr);
   assign busy = (state_reg == NVAC_PROGRAM);
   assign write_start = ctl_wr && i_reg_wdata[NVAC_BIT_WRITE] && master_write_arm_reg // [R07]
      && !busy && !i_srst && !i_flash_selfprog_busy; // [R13]
   assign read_start = ctl_wr && i_reg_wdata[NVAC_BIT_READ] && !busy && !write_start; // [R11]
   assign write_done = busy && i_tick_1mhz && (tick_count_reg == NVAC_WRITE_TICKS - 14'h0001); // [R12]

   // Write sequencer; reset does not abort a write in progress
   always_ff @(posedge i_sys_clk) begin
      if (i_srst && !busy) begin // [R17]
         state_reg <= NVAC_IDLE;
         tick_count_reg <= 14'h0000;
      end else begin
         case (state_reg)
            NVAC_IDLE: begin
               tick_count_reg <= 14'h0000;
               if (write_start) begin
                  state_reg <= NVAC_PROGRAM;
               end
            end
            NVAC_PROGRAM: begin
               // Timed only by oscillator ticks, so the main clock rate does not matter
               if (write_done) begin // [R12]
                  state_reg <= NVAC_IDLE;
                  tick_count_reg <= 14'h0000;
               end else if (i_tick_1mhz) begin
                  tick_count_reg <= tick_count_reg + 14'h0001;
               end
            end
            default: begin
               state_reg <= NVAC_IDLE;
               tick_count_reg <= 14'h0000;
            end
         endcase
      end
   end

   // Oscillator must keep running for a write, even in power-down
   assign o_osc_request = busy || i_power_down && busy; // [R16]

   // Write strobe: set at launch, held until the timer expires
   always_ff @(posedge i_sys_clk) begin
      if (write_done) begin
         write_strobe_reg <= 1'b0; // [R08]
      end else if (write_start) begin
         write_strobe_reg <= 1'b1; // [R08]
      end else if (i_srst && !busy) begin
         write_strobe_reg <= 1'b0; // [R18]
      end
   end

   // Arm bit with four-cycle self-clear window
   always_ff @(posedge i_sys_clk) begin
      if (i_srst && !busy) begin
         master_write_arm_reg <= 1'b0; // [R18]
         arm_count_reg <= 3'h0;
      end else if (ctl_wr && i_reg_wdata[NVAC_BIT_ARM]) begin
         master_write_arm_reg <= 1'b1;
         arm_count_reg <= NVAC_ARM_CYCLES;
      end else if (arm_count_reg == 3'h1) begin
         master_write_arm_reg <= 1'b0; // [R06]
         arm_count_reg <= 3'h0;
      end else if (arm_count_reg != 3'h0) begin
         arm_count_reg <= arm_count_reg - 3'h1; // [R06]
      end
   end

   // Ready interrupt enable bit
   always_ff @(posedge i_sys_clk) begin
      if (i_srst && !busy) begin
         ready_irq_enable_reg <= 1'b0; // [R18]
      end else if (ctl_wr) begin
         ready_irq_enable_reg <= i_reg_wdata[NVAC_BIT_RIE];
      end
   end

   // Level interrupt while idle; not cleared by servicing, only by disable
   assign o_ready_irq = ready_irq_enable_reg && i_global_irq_en && !write_strobe_reg; // [R05]

   // Address register, frozen during a write; no reset value
   always_ff @(posedge i_sys_clk) begin
      if (!busy && !write_start) begin // [R11]
         if (sel_hit(i_reg_sel, NVAC_SEL_ADDR_LOW, i_reg_wr)) begin
            nv_byte_address_reg[7:0] <= i_reg_wdata; // [R01]
         end
         if (sel_hit(i_reg_sel, NVAC_SEL_ADDR_HIGH, i_reg_wr)) begin
            nv_byte_address_reg[NVAC_BIT_ADDR_HI] <= i_reg_wdata[0]; // [R01]
         end
      end
   end

   // Data register: CPU write, or byte fetched one cycle after read strobe
   always_ff @(posedge i_sys_clk) begin
      if (read_pending_reg) begin
         nv_data_byte_reg <= mif.rdata; // [R10]
      end else if (sel_hit(i_reg_sel, NVAC_SEL_DATA, i_reg_wr)) begin
         nv_data_byte_reg <= i_reg_wdata; // [R04]
      end
   end

   // Read pending flag: array read data is registered one cycle
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         read_pending_reg <= 1'b0;
      end else begin
         read_pending_reg <= read_start; // [R10]
      end
   end

   // Array drive: write happens once, at launch, from the data register
   assign mif.addr = nv_byte_address_reg;
   assign mif.wdata = nv_data_byte_reg; // [R04]
   assign mif.we = write_start;

   // CPU stall counter; the stall covers the fetch cycle of a read
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         stall_count_reg <= 3'h0;
      end else if (write_start) begin
         stall_count_reg <= NVAC_WRITE_STALL; // [R09]
      end else if (read_start) begin
         stall_count_reg <= NVAC_READ_STALL; // [R10]
      end else if (stall_count_reg != 3'h0) begin
         stall_count_reg <= stall_count_reg - 3'h1;
      end
   end
   assign o_cpu_stall = (stall_count_reg != 3'h0);

   // Read mux, registered; reserved bits read as zero
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         rdata_reg <= NVAC_BYTE_ZERO;
      end else if (i_reg_rd) begin
         case (i_reg_sel)
            NVAC_SEL_ADDR_LOW: rdata_reg <= nv_byte_address_reg[7:0];
            NVAC_SEL_ADDR_HIGH: rdata_reg <= {7'h00, nv_byte_address_reg[NVAC_BIT_ADDR_HI]}; // [R02]
            NVAC_SEL_DATA: rdata_reg <= nv_data_byte_reg;
            NVAC_SEL_CONTROL: rdata_reg <= {4'h0, ready_irq_enable_reg, master_write_arm_reg,
               write_strobe_reg, 1'b0}; // [R02]
            default: rdata_reg <= NVAC_BYTE_ZERO;
         endcase
      end
   end
   assign o_reg_rdata = rdata_reg;
endmodule : nvac_ctrl

// ---- core/nvac_pkg.sv ----
// Package for the byte-wide nonvolatile access controller.
// Assumes one system clock at 200 MHz and a 1 MHz timing tick input.
package nvac_pkg;
   // Register select codes on the CPU register port
   localparam logic [1:0] NVAC_SEL_ADDR_LOW = 2'h0;
   localparam logic [1:0] NVAC_SEL_ADDR_HIGH = 2'h1;
   localparam logic [1:0] NVAC_SEL_DATA = 2'h2;
   localparam logic [1:0] NVAC_SEL_CONTROL = 2'h3;
   // Geometry
   localparam int NVAC_ADDR_W = 9;
   localparam int NVAC_DEPTH = 512;
   localparam logic [8:0] NVAC_ADDR_MAX = 9'h1ff;
   // Control and address bit positions
   localparam int NVAC_BIT_READ = 0;
   localparam int NVAC_BIT_WRITE = 1;
   localparam int NVAC_BIT_ARM = 2;
   localparam int NVAC_BIT_RIE = 3;
   localparam int NVAC_BIT_ADDR_HI = 8;
   // Timing: arm window and CPU stall lengths in system clocks
   localparam logic [2:0] NVAC_ARM_CYCLES = 3'h4;
   localparam logic [2:0] NVAC_WRITE_STALL = 3'h2;
   localparam logic [2:0] NVAC_READ_STALL = 3'h4;
   // Write time in oscillator ticks (8448 at 1 MHz, about 8.5 ms)
   localparam logic [13:0] NVAC_WRITE_TICKS = 14'h2100;
   localparam logic [7:0] NVAC_BYTE_ZERO = 8'h00;
   localparam logic [7:0] NVAC_BYTE_ERASED = 8'hff;
   // Controller state
   typedef enum logic [1:0] {
      NVAC_IDLE = 2'b00,
      NVAC_PROGRAM = 2'b01
   } nvac_state_t;
endpackage : nvac_pkg

// ---- core/nvac_mem_if.sv ----
// Interface joining the controller to its byte array.
// Assumes a single clock domain shared by both ends.
interface nvac_mem_if;
   logic [8:0] addr;
   logic [7:0] wdata;
   logic we;
   logic [7:0] rdata;
   modport ctrl (output addr, output wdata, output we, input rdata);
   modport mem (input addr, input wdata, input we, output rdata);
endinterface : nvac_mem_if

// ---- core/nvac_byte_array.sv ----
// Byte array standing in for the 512-byte nonvolatile store.
// Assumes the controller holds address steady around a write.
module nvac_byte_array (
   // Clock
   input wire logic i_sys_clk,
   // Array port
   nvac_mem_if.mem m
);
   import nvac_pkg::*;
   logic [7:0] mem_reg [NVAC_DEPTH];
   logic [7:0] rdata_reg;

   // Registered read, write on strobe; no reset so it keeps content
   always_ff @(posedge i_sys_clk) begin
      if (m.we) begin
         mem_reg[m.addr] <= m.wdata;
      end
      rdata_reg <= mem_reg[m.addr];
   end
   assign m.rdata = rdata_reg;
endmodule : nvac_byte_array

// ---- verification/nvac_ctrl_monitor.sv ----
// Port-level assertion checker for the nonvolatile access controller.
// Assumes it is bound to nvac_ctrl and sees only that module's ports.
module nvac_ctrl_monitor
   import nvac_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // CPU register port
   input wire logic [1:0] i_reg_sel,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   // Status and core side
   input wire logic i_global_irq_en,
   input wire logic i_flash_selfprog_busy,
   input wire logic i_power_down,
   input wire logic i_tick_1mhz,
   input wire logic o_cpu_stall,
   input wire logic o_ready_irq,
   input wire logic o_osc_request
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [13:0] tick_cnt;
   logic [2:0] stall_len;
   // Ticks seen while busy; no reset, since a write outlives reset
   always_ff @(posedge i_sys_clk) begin
      tick_cnt <= o_osc_request ? tick_cnt + 14'(i_tick_1mhz) : 14'h0000;
   end
   // Length of the current stall run
   always_ff @(posedge i_sys_clk) begin
      stall_len <= o_cpu_stall ? stall_len + 3'h1 : 3'h0;
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   property p_irq_gate; o_ready_irq |-> i_global_irq_en && !o_osc_request; endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("ready irq without cause");
   property p_stall_len; $fell(o_cpu_stall) |-> stall_len == 3'h2 || stall_len == 3'h4; endproperty
   a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
   property p_rdata_hold; !$past(i_reg_rd) |-> $stable(o_reg_rdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_ctl_upper; i_reg_rd && i_reg_sel == NVAC_SEL_CONTROL |=> o_reg_rdata[7:4] == 4'h0; endproperty
   a_ctl_upper: assert property (p_ctl_upper) else $error("control upper bits set");
   property p_hi_upper; i_reg_rd && i_reg_sel == NVAC_SEL_ADDR_HIGH |=> o_reg_rdata[7:1] == 7'h00; endproperty
   a_hi_upper: assert property (p_hi_upper) else $error("address high upper bits set");
   property p_launch;
      $rose(o_osc_request) |-> $past(i_reg_wr) && $past(i_reg_sel) == NVAC_SEL_CONTROL && $past(i_reg_wdata[1]);
   endproperty
   a_launch: assert property (p_launch) else $error("write began without strobe");
   property p_flash_block; $rose(o_osc_request) |-> !$past(i_flash_selfprog_busy); endproperty
   a_flash_block: assert property (p_flash_block) else $error("write began under flash busy");
   property p_write_len; $fell(o_osc_request) |-> tick_cnt == 14'h2100; endproperty
   a_write_len: assert property (p_write_len) else $error("write time wrong");
endmodule : nvac_ctrl_monitor

bind nvac_ctrl nvac_ctrl_monitor mon_u (.i_sys_clk, .i_srst, .i_reg_sel, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
   .o_reg_rdata, .i_global_irq_en, .i_flash_selfprog_busy, .i_power_down, .i_tick_1mhz, .o_cpu_stall,
   .o_ready_irq, .o_osc_request);

// ---- verification/nvac_osc_model.sv ----
// Calibrated oscillator model feeding the write timer.
// Assumes the bench clock; PERIOD sets clocks per tick.
module nvac_osc_model #(parameter int PERIOD = 200) (
   input wire logic i_sys_clk,
   output logic o_tick = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   // Free running, ignores sleep and reset like the real source
   always @(posedge i_sys_clk) begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      o_tick <= #1 (cnt == PERIOD - 1);
   end
endmodule : nvac_osc_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the nonvolatile access controller.
// Assumes the checker binds itself; tick runs every 3 clocks.
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
   $display("FAIL %s exp %h got %h", nm, e, a); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import nvac_pkg::*;
   logic i_sys_clk = 0, i_srst = 1, i_reg_wr = 0, i_reg_rd = 0, rd_d = 0, tick;
   logic i_global_irq_en = 1, i_flash_selfprog_busy = 0, i_power_down = 0;
   logic [1:0] i_reg_sel = 2'h0;
   logic [7:0] i_reg_wdata = 8'h00, d, o_reg_rdata;
   logic o_cpu_stall, o_ready_irq, o_osc_request;
   logic [15:0] notes[$];
   logic [15:0] nt;
   int n_errors = 0, comparisons = 0, seed = 32'h7c4765e2, k;
   initial begin
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end
   nvac_osc_model #(.PERIOD(3)) osc_u (.i_sys_clk, .o_tick(tick));
   nvac_ctrl dut_u (.i_sys_clk, .i_srst, .i_reg_sel, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata,
      .i_global_irq_en, .i_flash_selfprog_busy, .i_power_down, .i_tick_1mhz(tick), .o_cpu_stall,
      .o_ready_irq, .o_osc_request);
   task automatic wr(input logic [1:0] s, input logic [7:0] v);
      @(posedge i_sys_clk);
      #1 i_reg_sel = s;
      i_reg_wdata = v;
      i_reg_wr = 1;
      @(posedge i_sys_clk);
      #1 i_reg_wr = 0;
   endtask : wr
   // Note the masked expectation, then issue the read
   task automatic rd(input logic [1:0] s, input logic [7:0] m, input logic [7:0] e);
      notes.push_back({m, e & m});
      @(posedge i_sys_clk);
      #1 i_reg_sel = s;
      i_reg_rd = 1;
      @(posedge i_sys_clk);
      #1 i_reg_rd = 0;
   endtask : rd
   // Bounded poll, looking off the edge; running out counts as a mismatch
   task automatic wait_done;
      k = 0;
      while (o_osc_request !== 1'b0 && k < 40000) begin
         @(posedge i_sys_clk);
         #1 k++;
      end
      if (k >= 40000) begin
         n_errors++;
         wrap_up();
      end
   endtask : wait_done
   task automatic wrap_up;
      if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   // Answer lands one cycle after the read edge
   always @(posedge i_sys_clk) rd_d <= i_reg_rd;
   always @(negedge i_sys_clk) begin
      if (rd_d) begin
         nt = notes.pop_front();
         `CHK("rdata", nt[7:0], o_reg_rdata & nt[15:8])
      end
   end
   // Watchdog: two writes of 8448 ticks at 3 clocks each need about 51k clocks
   initial begin
      #400000 n_errors++;
      wrap_up();
   end
   initial begin
      d = 8'($random(seed));
      repeat (12) @(posedge i_sys_clk);
      #1 i_srst = 0;
      rd(NVAC_SEL_CONTROL, 8'hff, 8'h00);
      wr(NVAC_SEL_ADDR_HIGH, 8'hff);
      wr(NVAC_SEL_ADDR_LOW, 8'ha5);
      wr(NVAC_SEL_DATA, d);
      rd(NVAC_SEL_ADDR_HIGH, 8'hff, 8'h01);
      // Late strobe, then strobe under flash busy: both ignored
      wr(NVAC_SEL_CONTROL, 8'h04);
      repeat (5) @(posedge i_sys_clk);
      wr(NVAC_SEL_CONTROL, 8'h02);
      i_flash_selfprog_busy = 1;
      wr(NVAC_SEL_CONTROL, 8'h04);
      wr(NVAC_SEL_CONTROL, 8'h06);
      i_flash_selfprog_busy = 0;
      `CHK("idle", 1'b0, o_osc_request)
      wr(NVAC_SEL_CONTROL, 8'h0c);
      wr(NVAC_SEL_CONTROL, 8'h0e);
      `CHK("stall", 1'b1, o_cpu_stall)
      `CHK("busy", 1'b1, o_osc_request)
      `CHK("irq_busy", 1'b0, o_ready_irq)
      i_power_down = 1;
      wr(NVAC_SEL_ADDR_LOW, 8'h00);
      wr(NVAC_SEL_CONTROL, 8'h09);
      rd(NVAC_SEL_CONTROL, 8'hfb, 8'h0a);
      wait_done();
      `CHK("irq_ready", 1'b1, o_ready_irq)
      // Interrupts off from here on, as software should keep them around writes
      i_global_irq_en = 0;
      @(posedge i_sys_clk);
      #1 `CHK("irq_gie", 1'b0, o_ready_irq)
      rd(NVAC_SEL_ADDR_LOW, 8'hff, 8'ha5);
      wr(NVAC_SEL_DATA, ~d);
      wr(NVAC_SEL_CONTROL, 8'h09);
      `CHK("stall_rd", 1'b1, o_cpu_stall)
      repeat (6) @(posedge i_sys_clk);
      rd(NVAC_SEL_DATA, 8'hff, d);
      // Second write with a reset in mid-flight; the write keeps running
      wr(NVAC_SEL_ADDR_LOW, 8'h00);
      wr(NVAC_SEL_ADDR_HIGH, 8'h00);
      wr(NVAC_SEL_DATA, ~d);
      wr(NVAC_SEL_CONTROL, 8'h04);
      wr(NVAC_SEL_CONTROL, 8'h02);
      i_srst = 1;
      repeat (3) @(posedge i_sys_clk);
      #1 i_srst = 0;
      `CHK("reset_busy", 1'b1, o_osc_request)
      wait_done();
      i_power_down = 0;
      rd(NVAC_SEL_CONTROL, 8'hff, 8'h00);
      wr(NVAC_SEL_DATA, d);
      wr(NVAC_SEL_CONTROL, 8'h01);
      repeat (6) @(posedge i_sys_clk);
      rd(NVAC_SEL_DATA, 8'hff, ~d);
      repeat (3) @(posedge i_sys_clk);
      wrap_up();
   end
endmodule : tb_top
